/* File: sac_pkg.sv */
// constants, register map and timing of the converter sequencer control block
// Behaviour
// - resolution selectable as 12, 10, 8, 6 bits
// - result in 16-bit register, left or right aligned
// - nineteen channel codes, reserved codes never selected
// - single channel or scan, several operating modes
// - single mode converts sequence once per trigger
// - continuous mode repeats without further trigger
// - oversampling accumulates up to 256 samples
// - three window watchdogs flag out-of-range values
// - wait mode holds conversion until result read
// - auto-off powers converter only during power-up, sampling and conversion
// - autonomous: power on trigger, off after, DMA
// - software or hardware trigger, selectable polarity
// - interrupts on sampling, conversion, sequence, watchdog, overrun
// - enabled interrupt raises wake-up request
// - full resolution takes 0.4 us, fewer bits faster
package sac_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_NS = 400;
	localparam int PWRUP_TIME_NS = 20;
	localparam int CONV_CYC_12 = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [7:0] CONV_CYC_W12 = 8'(CONV_CYC_12);
	localparam logic [7:0] CONV_CYC_W10 = 8'(CONV_CYC_12 * 10 / 12);
	localparam logic [7:0] CONV_CYC_W8 = 8'(CONV_CYC_12 * 8 / 12);
	localparam logic [7:0] CONV_CYC_W6 = 8'(CONV_CYC_12 * 6 / 12);
	localparam logic [7:0] PWRUP_CYC = 8'((PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SMP_RST = 8'h04;
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHSEL = 8'h04;
	localparam logic [7:0] OFS_OVS = 8'h08;
	localparam logic [7:0] OFS_SMP = 8'h0c;
	localparam logic [7:0] OFS_WD0 = 8'h10;
	localparam logic [7:0] OFS_WD1 = 8'h14;
	localparam logic [7:0] OFS_WD2 = 8'h18;
	localparam logic [7:0] OFS_DATA = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam logic [7:0] OFS_MASK = 8'h28;
	localparam logic [7:0] OFS_STATE = 8'h2c;
	// control fields
	localparam int CTL_EN = 0;
	localparam int CTL_START = 1;
	localparam int CTL_RES = 2;
	localparam int CTL_ALIGN = 4;
	localparam int CTL_CONT = 5;
	localparam int CTL_DISC = 6;
	localparam int CTL_WAIT = 7;
	localparam int CTL_AUTOFF = 8;
	localparam int CTL_DMA = 9;
	localparam int CTL_HWTRIG = 10;
	localparam int CTL_TSEL = 11;
	localparam int CTL_TPOL = 13;
	localparam int CTL_WAKE = 14;
	localparam int CTL_DLEN = 16;
	localparam logic [31:0] CTRL_WMASK = 32'h0007_7ffd;
	localparam logic [1:0] RES_12 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_8 = 2'h2;
	localparam logic [1:0] RES_6 = 2'h3;
	// status bits, shared by status and mask
	localparam int ST_EOSMP = 0;
	localparam int ST_EOC = 1;
	localparam int ST_EOS = 2;
	localparam int ST_OVR = 3;
	localparam int ST_AWD = 4;
	localparam int ST_W = 7;
	// channels: 0..8 external, 16 temperature, 17 reference, 18 core voltage
	localparam int NUM_CHAN = 19;
	localparam logic [18:0] CHAN_VALID = 19'h7_01ff;
	localparam int NUM_WD = 3;
	localparam int WD_LO = 0;
	localparam int WD_HI = 16;
	localparam int OVS_EN = 0;
	localparam int OVS_RATIO = 1;
	localparam int OVS_SHIFT = 4;
endpackage

/* File: sac_sequencer.sv */
// sequencer, register file and interrupt logic for the sar converter
`timescale 1ns/1ps
module sac_sequencer
	import sac_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// hardware triggers and converter core
	input wire logic [3:0] i_hw_trig,
	input wire logic [11:0] i_core_data,
	output logic o_conv_power,
	output logic o_sample,
	output logic o_convert,
	output logic [4:0] o_chan,
	// system
	output logic o_irq,
	output logic o_wakeup,
	output logic o_dma_req
);
	typedef enum logic [2:0] {ST_IDLE, ST_PWRUP, ST_HOLD, ST_SAMPLE, ST_CONV} sac_phase_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [18:0] chsel;
		logic [7:0] ovs;
		logic [7:0] smp;
		logic [NUM_WD-1:0][27:0] wd;
		logic [15:0] data;
		logic data_vld;
		logic [ST_W-1:0] stat;
		logic [ST_W-1:0] mask;
		sac_phase_t phase;
		logic [7:0] cnt;
		logic [4:0] chan;
		logic [2:0] dcnt;
		logic [7:0] ocnt;
		logic [19:0] acc;
		logic pend;
		logic run;
		logic [3:0] trig_s1;
		logic [3:0] trig_s2;
		logic trig_prev;
		logic [11:0] core_s1;
		logic [11:0] core_s2;
		logic [31:0] rdata;
		logic irq;
		logic wake;
		logic dma_req;
		logic power;
		logic sample;
		logic convert;
	} sac_state_t;

	sac_state_t r, n;
	logic [1:0] rst_sync;
	logic rst_n;
	logic trig_lvl, hw_edge, rd_data, rd_stat, any_chan, nxt_found, last, start_wr;
	logic [4:0] first_idx, nxt_idx;
	logic [ST_W-1:0] setv;
	logic [11:0] raw, res_mask;
	logic [3:0] rsh;
	logic [7:0] conv_cyc;
	logic [8:0] ratio_m1;
	logic [19:0] sum;
	logic [15:0] value;
	logic [11:0] wlo, whi;

	// reset is asserted at once but released only after two clean edges
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	always_comb begin
		n = r;
		setv = '0;
		value = '0;
		sum = '0;
		wlo = '0;
		whi = '0;
		last = 1'b0;
		start_wr = i_wr && (i_addr == OFS_CTRL) && i_wdata[CTL_START] && i_wdata[CTL_EN];
		n.trig_s1 = i_hw_trig;
		n.trig_s2 = r.trig_s1;
		n.core_s1 = i_core_data;
		n.core_s2 = r.core_s1;
		trig_lvl = r.trig_s2[r.ctrl[CTL_TSEL +: 2]];
		n.trig_prev = trig_lvl;
		hw_edge = r.ctrl[CTL_HWTRIG] &
			(r.ctrl[CTL_TPOL] ? (r.trig_prev & ~trig_lvl) : (~r.trig_prev & trig_lvl));
		if (hw_edge) begin
			n.pend = 1'b1;
		end
		unique case (r.ctrl[CTL_RES +: 2])
			RES_12: begin
				res_mask = 12'hfff;
				rsh = 4'h0;
				conv_cyc = CONV_CYC_W12;
			end
			RES_10: begin
				res_mask = 12'hffc;
				rsh = 4'h2;
				conv_cyc = CONV_CYC_W10;
			end
			RES_8: begin
				res_mask = 12'hff0;
				rsh = 4'h4;
				conv_cyc = CONV_CYC_W8;
			end
			RES_6: begin
				res_mask = 12'hfc0;
				rsh = 4'h6;
				conv_cyc = CONV_CYC_W6;
			end
		endcase
		raw = r.core_s2 & res_mask;
		// shift amount widened so that ratio code 7 gives 256 samples, not one
		ratio_m1 = (9'h001 << ({1'b0, r.ovs[OVS_RATIO +: 3]} + 4'h1)) - 9'h001;
		// scan order: lowest selected channel above the current one
		first_idx = '0;
		nxt_idx = '0;
		nxt_found = 1'b0;
		any_chan = |r.chsel;
		for (int i = NUM_CHAN - 1; i >= 0; i--) begin
			if (r.chsel[i]) begin
				first_idx = 5'(i);
				if (5'(i) > r.chan) begin
					nxt_idx = 5'(i);
					nxt_found = 1'b1;
				end
			end
		end
		// register writes; unmapped offsets are ignored
		if (i_wr) begin
			case (i_addr)
				OFS_CTRL: begin
					n.ctrl = i_wdata & CTRL_WMASK;
					if (start_wr) begin
						n.pend = 1'b1;
					end
				end
				// reserved channel codes cannot be selected
				OFS_CHSEL: n.chsel = i_wdata[18:0] & CHAN_VALID;
				OFS_OVS: n.ovs = i_wdata[7:0];
				OFS_SMP: n.smp = i_wdata[7:0];
				OFS_WD0: n.wd[0] = i_wdata[27:0];
				OFS_WD1: n.wd[1] = i_wdata[27:0];
				OFS_WD2: n.wd[2] = i_wdata[27:0];
				OFS_MASK: n.mask = i_wdata[ST_W-1:0];
				default: begin
				end
			endcase
		end
		rd_data = i_rd && (i_addr == OFS_DATA);
		rd_stat = i_rd && (i_addr == OFS_STAT);
		n.rdata = '0;
		if (i_rd) begin
			case (i_addr)
				OFS_CTRL: n.rdata = r.ctrl;
				OFS_CHSEL: n.rdata = {13'h0, r.chsel};
				OFS_OVS: n.rdata = {24'h0, r.ovs};
				OFS_SMP: n.rdata = {24'h0, r.smp};
				OFS_WD0: n.rdata = {4'h0, r.wd[0]};
				OFS_WD1: n.rdata = {4'h0, r.wd[1]};
				OFS_WD2: n.rdata = {4'h0, r.wd[2]};
				OFS_DATA: n.rdata = {16'h0, r.data};
				OFS_STAT: n.rdata = {25'h0, r.stat};
				OFS_MASK: n.rdata = {25'h0, r.mask};
				OFS_STATE: n.rdata = {24'h0, r.chan, r.power, r.run, r.data_vld};
				default: n.rdata = '0;
			endcase
		end
		if (rd_data) begin
			n.data_vld = 1'b0;
		end
		unique case (r.phase)
			ST_IDLE: begin
				// a paused subset waits for the next trigger
				if (r.ctrl[CTL_EN] && any_chan &&
					(r.pend || (r.run && !(r.ctrl[CTL_DISC] && r.dcnt == 3'h0)))) begin
					// a request landing in the taking cycle is kept, not lost
					n.pend = hw_edge || start_wr;
					if (!r.run) begin
						n.run = 1'b1;
						n.chan = first_idx;
						n.dcnt = '0;
					end
					// power up only when a conversion is due
					n.phase = r.ctrl[CTL_AUTOFF] ? ST_PWRUP : ST_HOLD;
					n.cnt = PWRUP_CYC;
				end
			end
			ST_PWRUP: begin
				n.cnt = r.cnt - 8'h01;
				if (r.cnt == 8'h01) begin
					n.phase = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// in wait mode, no new conversion while a result is unread
				if (!(r.ctrl[CTL_WAIT] && r.data_vld)) begin
					n.phase = ST_SAMPLE;
					n.cnt = r.smp;
				end
			end
			ST_SAMPLE: begin
				n.cnt = r.cnt - 8'h01;
				if (r.cnt <= 8'h01) begin
					setv[ST_EOSMP] = 1'b1;
					n.phase = ST_CONV;
					n.cnt = conv_cyc;
				end
			end
			ST_CONV: begin
				n.cnt = r.cnt - 8'h01;
				if (r.cnt == 8'h01) begin
					// window compare on each raw conversion
					for (int k = 0; k < NUM_WD; k++) begin
						wlo = r.wd[k][WD_LO +: 12];
						whi = r.wd[k][WD_HI +: 12];
						if (raw < wlo || raw > whi) begin
							setv[ST_AWD + k] = 1'b1;
						end
					end
					sum = r.acc + {8'h00, raw};
					if (r.ovs[OVS_EN] && {1'b0, r.ocnt} != ratio_m1) begin
						n.acc = sum;
						n.ocnt = r.ocnt + 8'h01;
						n.phase = ST_SAMPLE;
						n.cnt = r.smp;
					end else begin
						n.acc = '0;
						n.ocnt = '0;
						if (r.ovs[OVS_EN]) begin
							value = 16'(sum >> r.ovs[OVS_SHIFT +: 4]);
						end else if (r.ctrl[CTL_ALIGN]) begin
							value = {raw, 4'h0};
						end else begin
							value = 16'(raw >> rsh);
						end
						if (r.data_vld && !rd_data) begin
							setv[ST_OVR] = 1'b1;
						end
						n.data = value;
						n.data_vld = 1'b1;
						setv[ST_EOC] = 1'b1;
						n.phase = ST_IDLE;
						n.dcnt = r.dcnt + 3'h1;
						last = !nxt_found;
						if (last) begin
							setv[ST_EOS] = 1'b1;
							n.chan = first_idx;
							n.dcnt = '0;
							// single mode stops at sequence end
							n.run = r.ctrl[CTL_CONT] && !r.ctrl[CTL_DISC];
						end else begin
							n.chan = nxt_idx;
							if (r.ctrl[CTL_DISC] && r.dcnt == r.ctrl[CTL_DLEN +: 3]) begin
								n.dcnt = '0;
							end
						end
					end
				end
			end
		endcase
		if (!r.ctrl[CTL_EN]) begin
			n.phase = ST_IDLE;
			n.run = 1'b0;
			n.acc = '0;
			n.ocnt = '0;
		end
		// judged on the new control word, so one write may enable and start
		if (!n.ctrl[CTL_EN]) begin
			n.pend = 1'b0;
		end
		// sticky events, a set in the clearing cycle wins
		n.stat = (rd_stat ? '0 : r.stat) | setv;
		n.irq = |(n.stat & n.mask);
		n.wake = n.irq && n.ctrl[CTL_WAKE];
		n.dma_req = n.data_vld && n.ctrl[CTL_DMA];
		// converter off in idle and hold phases when auto-off is set, else on while enabled
		n.power = n.ctrl[CTL_EN] &&
			(!n.ctrl[CTL_AUTOFF] || (n.phase != ST_IDLE && n.phase != ST_HOLD));
		n.sample = (n.phase == ST_SAMPLE);
		n.convert = (n.phase == ST_CONV);
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.smp <= SMP_RST;
		end else begin
			r <= n;
		end
	end

	assign o_rdata = r.rdata;
	assign o_conv_power = r.power;
	assign o_sample = r.sample;
	assign o_convert = r.convert;
	assign o_chan = r.chan;
	assign o_irq = r.irq;
	assign o_wakeup = r.wake;
	assign o_dma_req = r.dma_req;

	AST_RES_CYCLES: assert property (@(posedge i_clk) disable iff (!rst_n)
		(r.phase == ST_SAMPLE && n.phase == ST_CONV && r.ctrl[CTL_RES +: 2] == RES_6)
		|=> r.cnt == CONV_CYC_W6) else $error("wrong conversion length at 6 bits");
	AST_CHAN_LEGAL: assert property (@(posedge i_clk) disable iff (!rst_n)
		r.phase == ST_SAMPLE |-> CHAN_VALID[r.chan]) else $error("reserved channel sampled");
	AST_AUTOFF_OFF: assert property (@(posedge i_clk) disable iff (!rst_n)
		(r.ctrl[CTL_AUTOFF] && (r.phase == ST_IDLE || r.phase == ST_HOLD))
		|-> !o_conv_power) else $error("converter powered while idle in auto-off");
	AST_WAIT_HOLD: assert property (@(posedge i_clk) disable iff (!rst_n)
		(r.phase == ST_HOLD && r.ctrl[CTL_WAIT] && r.data_vld && !rd_data && r.ctrl[CTL_EN])
		|=> r.phase == ST_HOLD) else $error("conversion started over unread result");
	AST_OVR_SET: assert property (@(posedge i_clk) disable iff (!rst_n)
		(r.phase == ST_CONV && r.cnt == 8'h01 && !r.ovs[OVS_EN] && r.data_vld && !rd_data)
		|=> r.stat[ST_OVR] && r.data_vld) else $error("overrun not flagged");
	AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_irq == |(r.stat & r.mask)) else $error("interrupt out of step with status");
	AST_SINGLE_STOP: assert property (@(posedge i_clk) disable iff (!rst_n)
		(setv[ST_EOS] && !r.ctrl[CTL_CONT] && r.ctrl[CTL_EN]) |=> !r.run)
		else $error("single mode kept running");
	AST_CONT_RESTART: assert property (@(posedge i_clk) disable iff (!rst_n)
		(setv[ST_EOS] && r.ctrl[CTL_CONT] && !r.ctrl[CTL_DISC] && r.ctrl[CTL_EN] && !i_wr)
		|=> r.run ##1 (r.phase != ST_IDLE || !r.ctrl[CTL_EN] || !any_chan))
		else $error("continuous mode did not restart");
	AST_DISC_PAUSE: assert property (@(posedge i_clk) disable iff (!rst_n)
		(r.phase == ST_IDLE && r.run && r.ctrl[CTL_DISC] && r.dcnt == 3'h0 && !r.pend)
		|=> r.phase == ST_IDLE) else $error("subset continued without trigger");
endmodule

/* File: sac_core_model.sv */
// behavioural converter core: a fixed code per channel while converting
`timescale 1ns/1ps
module sac_core_model (
	// converter control
	input wire logic i_clk,
	input wire logic i_power,
	input wire logic i_convert,
	input wire logic [4:0] i_chan,
	// result bits
	output logic [11:0] o_data
);
	logic [11:0] data_reg = 12'h000;
	always_ff @(posedge i_clk) begin
		if (i_power && i_convert) begin
			data_reg <= 12'h8c3 + 12'(i_chan) * 12'h051;
		end else begin
			// no valid result outside conversion, so the bits keep toggling
			data_reg <= ~data_reg;
		end
	end
	assign o_data = data_reg;
endmodule

/* File: tb.sv */
// self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module tb;
	import sac_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_hw_trig = 4'h0;
	logic [11:0] core_data;
	logic [31:0] o_rdata;
	logic o_conv_power, o_sample, o_convert, o_irq, o_wakeup, o_dma_req;
	logic [4:0] o_chan;
	logic [31:0] d, acc;
	int num_errors = 0;
	int n_checks = 0;
	int ccnt = 0;
	int scnt = 0;
	int unpow = 0;
	always #2 i_clk = ~i_clk;
	sac_sequencer sac_sequencer_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hw_trig(i_hw_trig),
		.i_core_data(core_data), .o_conv_power(o_conv_power), .o_sample(o_sample),
		.o_convert(o_convert), .o_chan(o_chan), .o_irq(o_irq), .o_wakeup(o_wakeup),
		.o_dma_req(o_dma_req));
	sac_core_model sac_core_model_i (.i_clk(i_clk), .i_power(o_conv_power),
		.i_convert(o_convert), .i_chan(o_chan), .o_data(core_data));
	always @(posedge i_clk) begin
		if (o_convert === 1'b1) ccnt <= ccnt + 1;
		if (o_sample === 1'b1) scnt <= scnt + 1;
		if (o_convert === 1'b1 && o_conv_power !== 1'b1) unpow <= unpow + 1;
	end
	function automatic logic [11:0] raw(input int ch);
		return 12'h8c3 + 12'(ch) * 12'h051;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// status reads clear, so the bits seen are gathered until bit b shows
	task automatic wait_st(input int b, input int n, output logic [31:0] a);
		logic [31:0] s;
		a = 32'h0;
		for (int i = 0; i < n && a[b] !== 1'b1; i++) begin
			rd(OFS_STAT, s);
			a = a | s;
		end
		chk(32'(a[b]), 32'h1);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#300us;
		num_errors++;
		end_of_test();
	end
	initial begin
		logic [7:0] ecyc;
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(OFS_SMP, d); chk(d, 32'h4);
		rd(8'h3c, d); chk(d, 32'h0);
		wr(OFS_CHSEL, 32'hffff_ffff);
		rd(OFS_CHSEL, d); chk(d, 32'h0007_01ff);
		wr(OFS_CTRL, 32'hffff_fffe);
		rd(OFS_CTRL, d); chk(d, 32'h0007_7ffc);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_WD0, 32'h0fff_0000);
		wr(OFS_WD1, 32'h0fff_0000);
		wr(OFS_WD2, 32'h0fff_0000);
		$display("test registers done");
		wr(OFS_CHSEL, 32'h8);
		for (int r = 0; r < 4; r++) begin
			for (int al = 0; al < 2; al++) begin
				ecyc = (r == 0) ? CONV_CYC_W12 : (r == 1) ? CONV_CYC_W10 :
					(r == 2) ? CONV_CYC_W8 : CONV_CYC_W6;
				ccnt = 0;
				scnt = 0;
				wr(OFS_CTRL, 32'(r << CTL_RES) | 32'(al << CTL_ALIGN) | 32'h3);
				wait_st(ST_EOS, 400, acc);
				rd(OFS_DATA, d);
				if (al == 0) chk(d, 32'(raw(3) >> (2 * r)));
				else chk(d, {16'h0, raw(3) & (12'hfff << (2 * r)), 4'h0});
				chk(32'(ccnt), 32'(ecyc));
				chk(32'(scnt), 32'(SMP_RST));
			end
		end
		repeat (200) @(posedge i_clk);
		rd(OFS_STAT, d); chk(32'(d[ST_EOC]), 32'h0);
		$display("test resolution done");
		wr(OFS_CHSEL, 32'h3);
		wr(OFS_CTRL, 32'h3);
		wait_st(ST_EOS, 400, acc);
		chk(32'(acc[ST_OVR]), 32'h1);
		rd(OFS_DATA, d); chk(d, 32'(raw(1)));
		wr(OFS_CTRL, 32'h83);
		repeat (400) @(posedge i_clk);
		rd(OFS_STAT, d); chk(d & 32'hc, 32'h0);
		rd(OFS_DATA, d); chk(d, 32'(raw(0)));
		wait_st(ST_EOS, 400, acc);
		chk(32'(acc[ST_OVR]), 32'h0);
		rd(OFS_DATA, d); chk(d, 32'(raw(1)));
		wr(OFS_CHSEL, 32'h7);
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, 32'h43);
			wait_st(ST_EOC, 400, acc);
			chk(32'(acc[ST_EOS]), 32'(k == 2));
			rd(OFS_DATA, d); chk(d, 32'(raw(k)));
		end
		wr(OFS_CHSEL, 32'h20);
		wr(OFS_CTRL, 32'ha3);
		for (int k = 0; k < 3; k++) begin
			wait_st(ST_EOC, 400, acc);
			rd(OFS_DATA, d); chk(d, 32'(raw(5)));
		end
		wr(OFS_CTRL, 32'h0);
		repeat (300) @(posedge i_clk);
		rd(OFS_DATA, d);
		rd(OFS_STAT, d);
		$display("test modes done");
		wr(OFS_MASK, 32'h2);
		wr(OFS_CHSEL, 32'h4);
		wr(OFS_CTRL, 32'h4301);
		repeat (10) @(posedge i_clk);
		#1 chk(32'(o_conv_power), 32'h0);
		unpow = 0;
		wr(OFS_CTRL, 32'h4303);
		for (int i = 0; i < 400 && o_irq !== 1'b1; i++) begin
			@(posedge i_clk);
			#1;
		end
		#1 chk(32'(o_irq), 32'h1);
		chk(32'(o_wakeup), 32'h1);
		chk(32'(o_dma_req), 32'h1);
		chk(32'(unpow), 32'h0);
		repeat (10) @(posedge i_clk);
		#1 chk(32'(o_conv_power), 32'h0);
		rd(OFS_DATA, d); chk(d, 32'(raw(2)));
		#1 chk(32'(o_dma_req), 32'h0);
		rd(OFS_STAT, d);
		repeat (2) @(posedge i_clk);
		#1 chk(32'(o_irq), 32'h0);
		wr(OFS_MASK, 32'h0);
		wr(OFS_CTRL, 32'h4303);
		repeat (300) @(posedge i_clk);
		#1 chk(32'(o_irq), 32'h0);
		rd(OFS_DATA, d);
		rd(OFS_STAT, d);
		$display("test interrupt done");
		wr(OFS_WD0, 32'h0100_0000);
		wr(OFS_OVS, 32'h8f);
		wr(OFS_CHSEL, 32'h1_0000);
		i_hw_trig <= 4'h2;
		wr(OFS_CTRL, 32'h2c01);
		repeat (5) @(posedge i_clk);
		i_hw_trig <= 4'h0;
		wait_st(ST_EOC, 20000, acc);
		chk(acc & 32'h70, 32'h10);
		rd(OFS_DATA, d); chk(d, 32'(raw(16)));
		$display("test trigger done");
		end_of_test();
	end
endmodule
